// file: core/bert_pkg.sv
// bit error rate tester: register map, field layout, constants and types
package bert_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_CTRL     = 8'h00;
    localparam logic [7:0] ADR_PATCFG   = 8'h04;
    localparam logic [7:0] ADR_SEED     = 8'h08;
    localparam logic [7:0] ADR_STATUS   = 8'h0C;
    localparam logic [7:0] ADR_BITS     = 8'h10;
    localparam logic [7:0] ADR_ERRS     = 8'h14;
    localparam logic [7:0] ADR_INT_STAT = 8'h18;
    localparam logic [7:0] ADR_INT_CLR  = 8'h1C;
    localparam logic [7:0] ADR_INT_EN   = 8'h20;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int C_ENA      = 0;
    localparam int C_TXLD     = 1;
    localparam int C_RXLD     = 2;
    localparam int C_PMU      = 3;
    localparam int C_SGL      = 4;
    localparam int C_PINSRC   = 5;
    localparam int C_TXINV    = 6;
    localparam int C_RXINV    = 7;
    localparam int C_NORESYNC = 8;
    localparam int P_LEN_LSB  = 0;
    localparam int P_TAP_LSB  = 8;
    localparam int P_REP      = 16;
    localparam int P_QRSS     = 17;
    localparam int P_RATE_LSB = 20;
    localparam int S_OOS      = 0;
    localparam int S_BEC      = 1;
    localparam int I_OOS      = 0;
    localparam int I_SYNC     = 1;
    localparam int I_ERR      = 2;
    localparam int I_PMU      = 3;
    localparam int INT_W      = 4;

    // ------------------------------------------------------------
    // reset values and write masks
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_RST    = 32'h00000000;
    localparam logic [31:0] PATCFG_RST  = 32'h00000000;
    localparam logic [31:0] SEED_RST    = 32'hFFFFFFFF;
    localparam logic [31:0] CTRL_MASK   = 32'h000001EF;
    localparam logic [31:0] PATCFG_MASK = 32'h00731F1F;

    // ------------------------------------------------------------
    // pattern engine sizes
    // ------------------------------------------------------------
    localparam int         GEN_W      = 32;
    localparam int         ERRC_W     = 24;
    localparam int         SYNC_BITS  = 32;
    localparam int         WIN_BITS   = 64;
    localparam int         ERR_LIMIT  = 6;
    localparam int         QRSS_TAP_A = 17;
    localparam int         QRSS_TAP_B = 20;
    localparam int         QRSS_RUN   = 14;
    localparam logic [5:0] SYNC_LAST  = 6'(SYNC_BITS - 1);
    localparam logic [5:0] WIN_LAST   = 6'(WIN_BITS - 1);
    localparam logic [2:0] ERR_LAST   = 3'(ERR_LIMIT - 1);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {RX_HUNT, RX_VERIFY, RX_SYNC} bert_rx_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } bert_wb_req_t;

endpackage : bert_pkg

// file: core/bert_core.sv
// bit error rate tester: pattern generator, receive monitor, wishbone registers
`timescale 1ns/10ps
module bert_core (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire bert_pkg::bert_wb_req_t wb_i,
    output logic [31:0]                wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  tx_en_i,
    output logic                       tx_data_o,
    input  wire logic                  rx_en_i,
    input  wire logic                  rx_data_i,
    input  wire logic                  manual_error_insert_input_i,
    output logic                       out_of_sync_flag_o,
    output logic                       error_count_nonzero_flag_o,
    output logic                       irq_o
);
    import bert_pkg::*;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic gen_fb(input logic [31:0] s, input logic [4:0] n1,
                                    input logic [4:0] y1, input logic rep,
                                    input logic qrss);
        logic f;
        if (qrss) begin
            f = s[QRSS_TAP_A-1] ^ s[QRSS_TAP_B-1];
        end else if (rep) begin
            f = s[n1];
        end else begin
            f = s[n1] ^ s[y1];
        end
        if (!rep && s[GEN_W-2:0] == '0) begin
            f = 1'b1;
        end
        return f;
    endfunction : gen_fb

    function automatic logic gen_out(input logic [31:0] s, input logic fb,
                                     input logic qrss);
        return (qrss && s[QRSS_RUN-1:0] == '0) ? 1'b1 : fb;
    endfunction : gen_out

    function automatic logic [23:0] decade_max(input logic [2:0] n);
        case (n)
            3'h1:    decade_max = 24'h000009;
            3'h2:    decade_max = 24'h000063;
            3'h3:    decade_max = 24'h0003E7;
            3'h4:    decade_max = 24'h00270F;
            3'h5:    decade_max = 24'h01869F;
            3'h6:    decade_max = 24'h0F423F;
            3'h7:    decade_max = 24'h98967F;
            default: decade_max = 24'h000000;
        endcase
    endfunction : decade_max

    function automatic logic [31:0] merge_sel(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_sel

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0]         ctrl;
    logic [31:0]         patcfg;
    logic [31:0]         seed;
    logic [INT_W-1:0]    int_en;
    logic [INT_W-1:0]    int_stat;
    logic                tx_ld_prev;
    logic                rx_ld_prev;
    logic                pmu_prev;
    logic                pin_prev;
    logic [31:0]         tx_gen;
    logic [23:0]         rate_cnt;
    logic                sgl_pend;
    logic [31:0]         rx_gen;
    bert_rx_state_t      rx_state;
    logic [5:0]          rx_phase;
    logic [2:0]          rx_errs_win;
    logic [31:0]         run_bits;
    logic [ERRC_W-1:0]   run_errs;
    logic [31:0]         rd_bits;
    logic [ERRC_W-1:0]   rd_errs;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire        wb_hit   = wb_i.cyc & wb_i.stb & ~wb_ack_o;
    wire        wr       = wb_hit & wb_i.we;
    wire        rd       = wb_hit & ~wb_i.we;
    wire        w_ctrl   = wr & (wb_i.adr == ADR_CTRL);
    wire        w_patcfg = wr & (wb_i.adr == ADR_PATCFG);
    wire        w_seed   = wr & (wb_i.adr == ADR_SEED);
    wire        w_int_en = wr & (wb_i.adr == ADR_INT_EN);
    wire        w_clr    = wr & (wb_i.adr == ADR_INT_CLR) & wb_i.sel[0];
    wire [INT_W-1:0] clr = w_clr ? wb_i.dat[INT_W-1:0] : '0;
    logic [31:0] rd_data;

    // ------------------------------------------------------------
    // configuration fields and control edges
    // ------------------------------------------------------------
    wire       ena  = ctrl[C_ENA];
    wire [4:0] n1   = patcfg[P_LEN_LSB +: 5];
    wire [4:0] y1   = patcfg[P_TAP_LSB +: 5];
    wire       rep  = patcfg[P_REP];
    wire       qrss = patcfg[P_QRSS] & ~patcfg[P_REP];
    wire [2:0] rate = patcfg[P_RATE_LSB +: 3];
    wire tx_ld_edge = ena & ctrl[C_TXLD] & ~tx_ld_prev;
    wire rx_ld_edge = ena & ctrl[C_RXLD] & ~rx_ld_prev;
    wire pmu_edge   = ctrl[C_PMU] & ~pmu_prev;
    wire pin_edge   = manual_error_insert_input_i & ~pin_prev;
    wire sgl_wr     = w_ctrl & wb_i.sel[0] & wb_i.dat[C_SGL];
    wire sgl_req    = ctrl[C_PINSRC] ? pin_edge : sgl_wr;

    // ------------------------------------------------------------
    // transmit path
    // ------------------------------------------------------------
    wire tx_step  = ena & tx_en_i & ~tx_ld_edge;
    wire tx_fb    = gen_fb(tx_gen, n1, y1, rep, qrss);
    wire tx_bit   = gen_out(tx_gen, tx_fb, qrss);
    wire rate_hit = (rate != 3'h0) && (rate_cnt == decade_max(rate));
    wire tx_flip  = rate_hit | sgl_pend;
    wire next_tx_data = tx_bit ^ tx_flip ^ ctrl[C_TXINV];
    wire [23:0] next_rate_cnt = (rate_hit || rate == 3'h0) ? 24'h000000
                                                           : rate_cnt + 24'h000001;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_gen    <= SEED_RST;
            rate_cnt  <= 24'h000000;
            sgl_pend  <= 1'b0;
            tx_data_o <= 1'b0;
        end else if (ce_i) begin
            sgl_pend <= (sgl_pend & ~tx_step) | sgl_req;
            if (tx_ld_edge) begin
                tx_gen   <= seed;
                rate_cnt <= 24'h000000;
            end else if (tx_step) begin
                tx_gen    <= {tx_gen[GEN_W-2:0], tx_fb};
                tx_data_o <= next_tx_data;
                rate_cnt  <= next_rate_cnt;
            end
        end
    end

    // ------------------------------------------------------------
    // receive pattern synchroniser
    // ------------------------------------------------------------
    wire        rx_bit   = rx_data_i ^ ctrl[C_RXINV];
    wire        rx_step  = ena & rx_en_i & ~rx_ld_edge;
    wire        rx_fb    = gen_fb(rx_gen, n1, y1, rep, qrss);
    wire        rx_exp   = gen_out(rx_gen, rx_fb, qrss);
    wire        rx_miss  = rx_bit ^ rx_exp;
    wire        hunting  = (rx_state == RX_HUNT);
    wire [31:0] next_rx_gen = hunting ? {rx_gen[GEN_W-2:0], rx_bit}
                                      : {rx_gen[GEN_W-2:0], rx_fb};
    wire [31:0] len_mask  = 32'hFFFFFFFF >> (5'h1F - n1);
    wire        rep_match = ((next_rx_gen ^ seed) & len_mask) == '0;
    wire        no_resync = ctrl[C_NORESYNC];
    wire        resync = (rx_state == RX_SYNC) & rx_miss &
                         (rx_errs_win == ERR_LAST) & ~no_resync;
    wire        go_sync = (rx_state == RX_VERIFY) & ~rx_miss &
                          (rx_phase == SYNC_LAST);
    bert_rx_state_t next_rx_state;
    logic [5:0]     next_rx_phase;
    logic [2:0]     next_errs_win;

    always_comb begin
        next_rx_state = rx_state;
        next_rx_phase = rx_phase + 6'h01;
        next_errs_win = 3'h0;
        case (rx_state)
            RX_HUNT: begin
                if (rep) begin
                    next_rx_phase = 6'h00;
                    if (rep_match) begin
                        next_rx_state = RX_VERIFY;
                    end
                end else if (rx_phase == SYNC_LAST) begin
                    next_rx_state = RX_VERIFY;
                    next_rx_phase = 6'h00;
                end
            end
            RX_VERIFY: begin
                if (rx_miss) begin
                    next_rx_state = RX_HUNT;
                    next_rx_phase = 6'h00;
                end else if (go_sync) begin
                    next_rx_state = RX_SYNC;
                    next_rx_phase = 6'h00;
                end
            end
            RX_SYNC: begin
                if (resync) begin
                    next_rx_state = RX_HUNT;
                    next_rx_phase = 6'h00;
                end else if (rx_phase != WIN_LAST) begin
                    next_errs_win = (rx_miss && rx_errs_win != ERR_LAST)
                                    ? rx_errs_win + 3'h1 : rx_errs_win;
                end
            end
            default: begin
                next_rx_state = RX_HUNT;
                next_rx_phase = 6'h00;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_gen      <= SEED_RST;
            rx_state    <= RX_HUNT;
            rx_phase    <= 6'h00;
            rx_errs_win <= 3'h0;
        end else if (ce_i) begin
            if (rx_ld_edge) begin
                rx_gen      <= seed;
                rx_state    <= RX_HUNT;
                rx_phase    <= 6'h00;
                rx_errs_win <= 3'h0;
            end else if (rx_step) begin
                rx_gen      <= next_rx_gen;
                rx_state    <= next_rx_state;
                rx_phase    <= next_rx_phase;
                rx_errs_win <= next_errs_win;
            end
        end
    end

    assign out_of_sync_flag_o = (rx_state != RX_SYNC);

    // ------------------------------------------------------------
    // bit and error counters
    // ------------------------------------------------------------
    wire count_bit = rx_step & (rx_state == RX_SYNC);
    wire count_err = count_bit & rx_miss;
    wire [31:0]       inc_bits = run_bits + 32'h00000001;
    wire [ERRC_W-1:0] inc_errs = run_errs + 24'h000001;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_bits <= 32'h00000000;
            run_errs <= 24'h000000;
            rd_bits  <= 32'h00000000;
            rd_errs  <= 24'h000000;
        end else if (ce_i) begin
            if (pmu_edge) begin
                rd_bits  <= run_bits;
                rd_errs  <= run_errs;
                run_bits <= count_bit ? 32'h00000001 : 32'h00000000;
                run_errs <= count_err ? 24'h000001 : 24'h000000;
            end else begin
                if (count_bit) begin
                    run_bits <= inc_bits;
                end
                if (count_err) begin
                    run_errs <= inc_errs;
                end
            end
        end
    end

    assign error_count_nonzero_flag_o = (run_errs != 24'h000000);

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    wire [INT_W-1:0] ev = {pmu_edge, count_err, rx_step & go_sync,
                           (rx_state == RX_SYNC) & (rx_ld_edge | (rx_step & resync))};
    assign irq_o = |(int_stat & int_en);

    // ------------------------------------------------------------
    // registers and bus slave
    // ------------------------------------------------------------
    always_comb begin
        rd_data = 32'h00000000;
        if (wb_i.adr == ADR_CTRL) begin
            rd_data = ctrl;
        end else if (wb_i.adr == ADR_PATCFG) begin
            rd_data = patcfg;
        end else if (wb_i.adr == ADR_SEED) begin
            rd_data = seed;
        end else if (wb_i.adr == ADR_STATUS) begin
            rd_data[S_OOS] = out_of_sync_flag_o;
            rd_data[S_BEC] = error_count_nonzero_flag_o;
        end else if (wb_i.adr == ADR_BITS) begin
            rd_data = rd_bits;
        end else if (wb_i.adr == ADR_ERRS) begin
            rd_data[ERRC_W-1:0] = rd_errs;
        end else if (wb_i.adr == ADR_INT_STAT) begin
            rd_data[INT_W-1:0] = int_stat;
        end else if (wb_i.adr == ADR_INT_EN) begin
            rd_data[INT_W-1:0] = int_en;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl       <= CTRL_RST;
            patcfg     <= PATCFG_RST;
            seed       <= SEED_RST;
            int_en     <= '0;
            int_stat   <= '0;
            tx_ld_prev <= 1'b0;
            rx_ld_prev <= 1'b0;
            pmu_prev   <= 1'b0;
            pin_prev   <= 1'b0;
            wb_ack_o   <= 1'b0;
            wb_dat_o   <= 32'h00000000;
        end else if (ce_i) begin
            tx_ld_prev <= ena & ctrl[C_TXLD];
            rx_ld_prev <= ena & ctrl[C_RXLD];
            pmu_prev   <= ctrl[C_PMU];
            pin_prev   <= manual_error_insert_input_i;
            int_stat   <= (int_stat & ~clr) | ev;
            wb_ack_o   <= wb_hit;
            wb_dat_o   <= rd ? rd_data : 32'h00000000;
            if (w_ctrl) begin
                ctrl <= merge_sel(ctrl, wb_i.dat, wb_i.sel) & CTRL_MASK;
            end
            if (w_patcfg) begin
                patcfg <= merge_sel(patcfg, wb_i.dat, wb_i.sel) & PATCFG_MASK;
            end
            if (w_seed) begin
                seed <= merge_sel(seed, wb_i.dat, wb_i.sel);
            end
            if (w_int_en && wb_i.sel[0]) begin
                int_en <= wb_i.dat[INT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_load_done;
        ce_i && hunting && !rep && rx_step && rx_phase == SYNC_LAST
        |=> rx_state == RX_VERIFY && out_of_sync_flag_o;
    endproperty
    a_load_done: assert property (p_load_done) else $error("load phase not 32 bits");

    property p_sync_entry;
        ce_i && rx_step && go_sync |=> rx_state == RX_SYNC && !out_of_sync_flag_o;
    endproperty
    a_sync_entry: assert property (p_sync_entry) else $error("sync not entered");

    property p_verify_fail;
        ce_i && rx_state == RX_VERIFY && rx_step && rx_miss |=> hunting;
    endproperty
    a_verify_fail: assert property (p_verify_fail) else $error("bad verify kept");

    property p_resync;
        ce_i && rx_state == RX_SYNC && rx_step && rx_miss &&
        rx_errs_win == ERR_LAST && !no_resync |=> hunting && out_of_sync_flag_o;
    endproperty
    a_resync: assert property (p_resync) else $error("sixth miss no resync");

    property p_no_resync;
        ce_i && rx_state == RX_SYNC && no_resync && !rx_ld_edge |=> rx_state == RX_SYNC;
    endproperty
    a_no_resync: assert property (p_no_resync) else $error("resync while disabled");

    property p_hold;
        ce_i && out_of_sync_flag_o && !pmu_edge |=> $stable(run_bits) && $stable(run_errs);
    endproperty
    a_hold: assert property (p_hold) else $error("counters moved out of sync");

    property p_count;
        ce_i && rx_state == RX_SYNC && rx_step && !pmu_edge
        |=> run_bits == $past(inc_bits) &&
            run_errs == ($past(rx_miss) ? $past(inc_errs) : $past(run_errs));
    endproperty
    a_count: assert property (p_count) else $error("bad count step");

    property p_pmu;
        ce_i && pmu_edge |=> rd_bits == $past(run_bits) && rd_errs == $past(run_errs);
    endproperty
    a_pmu: assert property (p_pmu) else $error("update copy wrong");

    property p_seed;
        ce_i && tx_ld_edge |=> tx_gen == $past(seed);
    endproperty
    a_seed: assert property (p_seed) else $error("seed not loaded");

    property p_shift;
        ce_i && tx_step |=> tx_gen[GEN_W-1:1] == $past(tx_gen[GEN_W-2:0]) &&
                            tx_gen[0] == $past(tx_fb);
    endproperty
    a_shift: assert property (p_shift) else $error("generator shift wrong");

    property p_nolock;
        ce_i && tx_step && !rep && tx_gen[GEN_W-2:0] == '0 |=> tx_gen[0];
    endproperty
    a_nolock: assert property (p_nolock) else $error("zero lockup");

    property p_rate;
        ce_i && tx_step && rate_hit && !ctrl[C_TXINV] |=> tx_data_o != $past(tx_bit);
    endproperty
    a_rate: assert property (p_rate) else $error("rate error missing");

    c_sync:   cover property (ce_i && rx_step && go_sync);
    c_resync: cover property (ce_i && rx_step && resync);
    c_pmu:    cover property (ce_i && pmu_edge && rx_state == RX_SYNC);

endmodule : bert_core

// file: tb/bert_framer_model.sv
// framer payload datapath model: bit strobes and loopback of the test stream
`timescale 1ns/10ps
module bert_framer_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic tx_data_i,
    output logic      tx_en_o,
    output logic      rx_en_o,
    output logic      rx_data_o
);
    // ------------------------------------------------------------
    // payload slots every other cycle, receive one cycle behind
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_en_o   <= 1'b0;
            rx_en_o   <= 1'b0;
            rx_data_o <= 1'b0;
        end else begin
            tx_en_o   <= ~tx_en_o;
            rx_en_o   <= tx_en_o;
            rx_data_o <= tx_data_i;
        end
    end
endmodule : bert_framer_model

// file: tb/bert_core_tb.sv
// self-checking bench for the bit error rate tester
`timescale 1ns/10ps
module bert_core_tb;
    import bert_pkg::*;
    logic                   clk_i = 1'b0;
    logic                   rst_i = 1'b1;
    bert_pkg::bert_wb_req_t wb    = '0;
    logic [31:0]            dat;
    logic                   ack, txd, txe, rxe, rxd, out_of_sync_flag, nz, irq;
    logic [31:0]            q;
    logic                   pin = 1'b0;
    int                     bad_count = 0;
    int                     comparisons = 0;
    int                     cycles = 0;
    int                     n;

    always #5 clk_i = ~clk_i;

    bert_core DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_i(wb), .wb_dat_o(dat),
        .wb_ack_o(ack), .tx_en_i(txe), .tx_data_o(txd), .rx_en_i(rxe), .rx_data_i(rxd),
        .manual_error_insert_input_i(pin), .out_of_sync_flag_o(out_of_sync_flag),
        .error_count_nonzero_flag_o(nz), .irq_o(irq));

    bert_framer_model fm (.clk_i(clk_i), .rst_i(rst_i), .tx_data_i(txd), .tx_en_o(txe),
        .rx_en_o(rxe), .rx_data_o(rxd));

    // ------------------------------------------------------------
    // bus access and compare
    // ------------------------------------------------------------
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb <= '{1'b1, 1'b1, we, 4'hF, a, d};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = dat;
        wb <= '0;
    endtask : bus

    // waits for the receiver to report sync; gives up after 2000 cycles if it never does
    task automatic wait_sync;
        n = 0;
        while (out_of_sync_flag !== 1'b0 && n < 2000) begin
            @(posedge clk_i);
            n++;
        end
    endtask : wait_sync

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("oos", 1, out_of_sync_flag);
        bus(0, ADR_SEED, 0);           chk("seed", 32'hFFFFFFFF, q);
        bus(0, 8'h40, 0);              chk("unmapped", 32'h00000000, q);
        bus(1, ADR_PATCFG, 32'h00000408);
        bus(1, ADR_CTRL, 32'h00000001);
        bus(1, ADR_CTRL, 32'h00000007);
        wait_sync();
        bus(0, ADR_STATUS, 0);         chk("status sync", 32'h00000000, q);
        bus(1, ADR_INT_EN, 32'h00000004);
        bus(1, ADR_CTRL, 32'h00000011);
        repeat (20) @(posedge clk_i);
        chk("irq", 1, irq);
        bus(1, ADR_CTRL, 32'h00000009);
        bus(0, ADR_ERRS, 0);           chk("errs", 32'h00000001, q);
        bus(0, ADR_STATUS, 0);         chk("still sync", 32'h00000000, q);
        bus(1, ADR_INT_CLR, 32'h00000004);
        @(posedge clk_i);
        chk("irq clr", 0, irq);
        // single error from the pin source
        bus(1, ADR_CTRL, 32'h00000021);
        @(posedge clk_i) pin <= 1'b1;
        @(posedge clk_i) pin <= 1'b0;
        repeat (20) @(posedge clk_i);
        chk("nonzero", 1, nz);
        bus(0, ADR_STATUS, 0);         chk("status err", 32'h00000002, q);
        bus(1, ADR_CTRL, 32'h00000029);
        bus(0, ADR_ERRS, 0);           chk("pin errs", 32'h00000001, q);
        // update strobes ten cycles apart span five payload bits
        @(posedge clk_i);
        bus(1, ADR_CTRL, 32'h00000021);
        bus(1, ADR_CTRL, 32'h00000029);
        bus(0, ADR_BITS, 0);           chk("bits", 32'h00000005, q);
        // one error per ten bits forces a resync that cannot settle
        bus(1, ADR_PATCFG, 32'h00100408);
        repeat (300) @(posedge clk_i);
        chk("lost sync", 1, out_of_sync_flag);
        bus(0, ADR_INT_STAT, 0);       chk("int stat", 32'h0000000F, q);
        bus(1, ADR_PATCFG, 32'h00000408);
        wait_sync();
        chk("resync", 0, out_of_sync_flag);
        // same error rate with automatic resync disabled
        bus(1, ADR_CTRL, 32'h00000101);
        bus(1, ADR_PATCFG, 32'h00100408);
        repeat (300) @(posedge clk_i);
        chk("held sync", 0, out_of_sync_flag);
        tally_and_finish();
    end
endmodule : bert_core_tb
